/* dv/host_model.sv */
// host end of the two-wire bus, paced by the system clock
// assumes the bench resolves sda with a pull-up
`timescale 1ns/100ps
module host_model (
  input  logic sys_clk_in, // pacing clock
  input  logic sda_in,     // resolved sda
  output logic scl_out,    // bus clock, still between frames
  output logic sda_oe_out  // high while pulling sda low
);
  // ********
  // bus cycles
  // ********
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // data moves a cycle into scl low so it never races the fall
  task bit_x(input logic b, output logic r);
    tick(1);
    sda_oe_out = !b;
    tick(3);
    scl_out = 1'b1;
    tick(4);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  // s=1: start (also repeated), s=0: stop
  task cond(input logic s);
    tick(1);
    sda_oe_out = !s;
    tick(3);
    scl_out = 1'b1;
    tick(4);
    sda_oe_out = s;
    tick(6);
    if (s) scl_out = 1'b0;
  endtask
  task wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task rbyte(output logic [7:0] v, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(!ack, r);
  endtask
  // nine idle clocks with sda seen high, then a start
  task recover(output logic ok);
    logic r;
    ok = 1'b1;
    repeat (9) begin
      bit_x(1'b1, r);
      ok = ok & r;
    end
    cond(1'b1);
  endtask
endmodule

/* dv/tb_top.sv */
// self-checking bench for the two-wire framing block and its buffer
// assumes the host model paces scl at 32 ns from the system clock
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
module tb_top;
  logic       sys_clk_in = 1'b0;
  logic       srst_in = 1'b1;
  logic       rx_ready_in = 1'b0;
  logic [7:0] tx_data_in = 8'ha5;
  logic       a;
  logic [7:0] v;
  wire        sda;
  wire        scl;
  wire        h_oe;
  wire        sda_oe_out;
  wire        sda_out;
  wire        rx_valid_out;
  wire        tx_ready_out;
  wire        standby_out;
  wire        write_busy_out;
  wire        write_done_out;
  wire  [7:0] rx_data_out;
  int         err_total = 0;
  int         n_checks = 0;
  int         n_tx = 0;
  int         n_done = 0;
  // ********
  // bus and design
  // ********
  assign sda = !(h_oe | sda_oe_out); // open drain with pull-up
  initial forever #2 sys_clk_in = !sys_clk_in;
  // one-cycle pulses are counted at the edge after their launch
  always @(posedge sys_clk_in) begin
    if (tx_ready_out === 1'b1) n_tx <= n_tx + 1;
    if (write_done_out === 1'b1) n_done <= n_done + 1;
  end
  host_model h (
    .sys_clk_in (sys_clk_in),
    .sda_in     (sda),
    .scl_out    (scl),
    .sda_oe_out (h_oe)
  );
  two_wire_bus_framing #(
    .WRITE_CYCLES (600)
  ) i_dut (
    .sys_clk_in     (sys_clk_in),
    .srst_in        (srst_in),
    .scl_in         (scl),
    .sda_in         (sda),
    .sda_out        (sda_out),
    .sda_oe_out     (sda_oe_out),
    .rx_data_out    (rx_data_out),
    .rx_valid_out   (rx_valid_out),
    .rx_ready_in    (rx_ready_in),
    .tx_data_in     (tx_data_in),
    .tx_ready_out   (tx_ready_out),
    .standby_out    (standby_out),
    .write_busy_out (write_busy_out),
    .write_done_out (write_done_out)
  );
  // the trailing edge keeps two pops from toggling ready in one step
  task pop(input logic [7:0] e);
    for (int k = 0; k < 50 && rx_valid_out !== 1'b1; k++) h.tick(1);
    `CHK(rx_valid_out, 1'b1)
    `CHK(rx_data_out, e)
    rx_ready_in = 1'b1;
    h.tick(1);
    rx_ready_in = 1'b0;
    h.tick(1);
  endtask
  // e is the number of finished internal writes expected so far
  task wait_write(input int e);
    for (int k = 0; k < 700 && write_busy_out === 1'b1; k++) h.tick(1);
    h.tick(1);
    `CHK(write_busy_out, 1'b0)
    `CHK(n_done, e)
  endtask
  task t_write;
    h.cond(1'b1);
    h.wbyte(8'h5a, a);
    `CHK(a, 1'b1)
    h.wbyte(8'hc3, a);
    `CHK(a, 1'b1)
    h.cond(1'b0);
    `CHK(write_busy_out, 1'b1)
    h.cond(1'b1);
    h.wbyte(8'h3c, a);
    `CHK(a, 1'b0)
    h.cond(1'b0);
    pop(8'h5a);
    pop(8'hc3);
    wait_write(1);
    $display("test write done");
  endtask
  task t_read;
    int tx_base;
    tx_base = n_tx;
    h.cond(1'b1);
    h.wbyte(8'h01, a);
    `CHK(a, 1'b1)
    h.rbyte(v, 1'b1);
    `CHK(v, 8'ha5)
    tx_data_in = 8'h96;
    h.rbyte(v, 1'b0);
    `CHK(v, 8'h96)
    h.cond(1'b0);
    `CHK(standby_out, 1'b1)
    `CHK(n_tx - tx_base, 2)
    pop(8'h01);
    $display("test read done");
  endtask
  // words with no start before them must be ignored
  task t_idle;
    logic ok;
    h.scl_out = 1'b0;
    h.wbyte(8'h00, a);
    `CHK(a, 1'b0)
    h.recover(ok);
    `CHK(ok, 1'b1)
    `CHK(standby_out, 1'b0)
    h.wbyte(8'h5a, a);
    `CHK(a, 1'b1)
    h.cond(1'b0);
    h.scl_out = 1'b0;
    h.wbyte(8'hff, a);
    `CHK(a, 1'b0)
    pop(8'h5a);
    `CHK(rx_valid_out, 1'b0)
    $display("test idle done");
  endtask
  // user stalls: 17 words fit, the 18th is refused by a missing ack;
  // the acked words are still written once the stop arrives
  task t_fifo;
    h.cond(1'b1);
    for (int i = 0; i < 18; i++) begin
      h.wbyte(8'h20 + 8'(i), a);
      `CHK(a, 1'(i < 17))
    end
    h.cond(1'b0);
    `CHK(write_busy_out, 1'b1)
    for (int i = 0; i < 17; i++) pop(8'h20 + 8'(i));
    `CHK(rx_valid_out, 1'b0)
    wait_write(2);
    $display("test fifo done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_in);
    #1 srst_in = 1'b0;
    `CHK(sda_oe_out, 1'b0)
    `CHK(standby_out, 1'b0)
    h.tick(3);
    t_write;
    t_read;
    t_idle;
    t_fifo;
    summarize;
  end
  // watchdog: the tests need well under 10000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    err_total++;
    summarize;
  end
endmodule

/* dv/two_wire_monitor.sv */
// port assertions for the two-wire framing block
// assumes scl from the bench is no faster than 8 system clocks a period
`timescale 1ns/100ps
module two_wire_monitor #(
  parameter WRITE_CYCLES = 64
) (
  input logic sys_clk_in,     // system clock
  input logic srst_in,        // reset
  input logic scl_in,         // bus clock
  input logic sda_in,         // bus data
  input logic sda_out,        // driven level
  input logic sda_oe_out,     // pull enable
  input logic tx_ready_out,   // send word taken
  input logic standby_out,    // standby level
  input logic write_busy_out, // write running
  input logic write_done_out  // write over
);
  // ********
  // checks
  // ********
  int busy_cnt = 0;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // busy needs no reset: it is held low while reset is up
  always @(posedge sys_clk_in) busy_cnt <= write_busy_out ? busy_cnt + 1 : 0;
  oe_scl_low_a:
    assert property ($changed(sda_oe_out) |-> !$past(scl_in))
    else $error("sda enable moved with scl high");
  open_drain_a:
    assert property (sda_out == 1'b0) else $error("sda driven high");
  ack_hold_a:
    assert property ($rose(sda_oe_out) |-> sda_oe_out[*6])
    else $error("low level too short");
  nack_busy_a:
    assert property (write_busy_out |-> !$rose(sda_oe_out))
    else $error("ack during write");
  busy_len_a:
    assert property ($fell(write_busy_out) |-> busy_cnt == WRITE_CYCLES)
    else $error("write length wrong");
  done_end_a:
    assert property ($fell(write_busy_out) |-> write_done_out)
    else $error("no done at write end");
  done_pulse_a:
    assert property (write_done_out |=> !write_done_out)
    else $error("done too long");
  tx_pulse_a:
    assert property (tx_ready_out |=> !tx_ready_out)
    else $error("send take too long");
  standby_stop_a:
    assert property ($rose(standby_out) |-> scl_in && sda_in)
    else $error("standby without stop");
endmodule
bind two_wire_bus_framing two_wire_monitor #(
  .WRITE_CYCLES (WRITE_CYCLES)
) u_mon (
  .sys_clk_in     (sys_clk_in),
  .srst_in        (srst_in),
  .scl_in         (scl_in),
  .sda_in         (sda_in),
  .sda_out        (sda_out),
  .sda_oe_out     (sda_oe_out),
  .tx_ready_out   (tx_ready_out),
  .standby_out    (standby_out),
  .write_busy_out (write_busy_out),
  .write_done_out (write_done_out)
);

/* inc/two_wire_defines.vh */
// constants for the two-wire bus framing block
// assumes a 250 MHz system clock and a host that drives the bus
`ifndef TWO_WIRE_DEFINES_VH
`define TWO_WIRE_DEFINES_VH

// ***************************************************************
// word framing
// ***************************************************************
`define TWB_WORD_BITS      8
`define TWB_LAST_BIT       3'h7
`define TWB_READ_FLAG_BIT  0

// ***************************************************************
// receive buffer shape
// ***************************************************************
`define TWB_FIFO_WIDTH     8
`define TWB_FIFO_DEPTH     16

// ***************************************************************
// timing
// ***************************************************************
`define TWB_CLK_MHZ        250
// internal write time, room temperature and full range, in ms
`define TWB_WRITE_TIME_MS      5
`define TWB_WRITE_TIME_MAX_MS  7
// cycles of the internal write (room temperature time, exact)
`define TWB_WRITE_CYCLES (`TWB_WRITE_TIME_MS * 1000 * `TWB_CLK_MHZ)
`define TWB_WRITE_CNT_BITS 21

`endif

/* logic/two_wire_bus_framing.v */
// two-wire bus framing, device end, with its receive buffer
// assumes scl and sda arrive asynchronously from an open-drain bus
`timescale 1ns/100ps
`include "two_wire_defines.vh"

// ***************************************************************
// receive buffer
// ***************************************************************
module byte_fifo #(
  parameter WIDTH = `TWB_FIFO_WIDTH,
  parameter DEPTH = `TWB_FIFO_DEPTH
) (
  input  wire             clk_in,       // system clock
  input  wire             rst_in,       // synchronous reset
  input  wire             in_valid_in,  // write request
  output wire             in_ready_out, // not full
  input  wire [WIDTH-1:0] in_data_in,   // write data
  output wire             out_valid_out,// not empty
  input  wire             out_ready_in, // read request
  output wire [WIDTH-1:0] out_data_out  // head word
);
  localparam AW = $clog2(DEPTH);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full;
  wire            empty;

  // extra pointer bit tells full from empty
  assign full          = (wr_ptr[AW] != rd_ptr[AW]) &&
                         (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty         = (wr_ptr == rd_ptr);
  assign in_ready_out  = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out  = mem[rd_ptr[AW-1:0]];

  // pointer and storage update
  always @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (in_valid_in && !full) begin
        mem[wr_ptr[AW-1:0]] <= in_data_in;
        wr_ptr              <= wr_ptr + 1'b1;
      end
      if (out_ready_in && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ***************************************************************
// bus framing engine
// ***************************************************************
//
// Contract
// - sda moves only while scl low
// - start is sda falling, scl high
// - sda rising with scl high is stop
// - stop after read enters standby
// - all words move as eight bits
// - device pulls sda low on ninth clock; the code leaves sda high there when the buffer is full or a write runs
// - internal write ends within 5 ms
// - sample on scl rise, drive after fall
module two_wire_bus_framing #(
  parameter WRITE_CYCLES = `TWB_WRITE_CYCLES
) (
  input  wire       sys_clk_in,     // 250 MHz system clock
  input  wire       srst_in,        // synchronous reset, high
  input  wire       scl_in,         // bus clock from host
  input  wire       sda_in,         // bus data level
  output reg        sda_out,        // driven level, always low
  output reg        sda_oe_out,     // high while pulling sda low
  output reg  [7:0] rx_data_out,    // received word
  output reg        rx_valid_out,   // received word waiting
  input  wire       rx_ready_in,    // user takes received word
  input  wire [7:0] tx_data_in,     // word to send on reads
  output reg        tx_ready_out,   // pulse: tx_data_in taken
  output reg        standby_out,    // low-power standby level
  output reg        write_busy_out, // internal write running
  output reg        write_done_out  // pulse: internal write over
);
  localparam [2:0] ST_IDLE    = 3'h0;
  localparam [2:0] ST_RX      = 3'h1;
  localparam [2:0] ST_RX_ACK  = 3'h2;
  localparam [2:0] ST_ACK     = 3'h3;
  localparam [2:0] ST_TX      = 3'h4;
  localparam [2:0] ST_TX_REL  = 3'h5;
  localparam [2:0] ST_TX_ACK  = 3'h6;
  localparam [2:0] ST_TX_LOAD = 3'h7;
  localparam [31:0] WR_LAST_W = WRITE_CYCLES - 1;
  localparam [`TWB_WRITE_CNT_BITS-1:0] WR_LAST =
    WR_LAST_W[`TWB_WRITE_CNT_BITS-1:0];

  reg        scl_s1, scl_s2, scl_d;
  reg        sda_s1, sda_s2, sda_d;
  reg  [2:0] state;
  reg  [2:0] bit_cnt;
  reg  [7:0] shift;
  reg        first_word;
  reg        is_read;
  reg        wrote;
  reg        push;
  reg  [7:0] push_data;
  reg  [`TWB_WRITE_CNT_BITS-1:0] wr_cnt;
  wire       scl_rise, scl_fall, start_seen, stop_seen;
  wire       fifo_in_ready, fifo_out_valid, fifo_take;
  wire [7:0] fifo_out_data;

  // ***************************************************************
  // pin synchronisers and edge finding
  // ***************************************************************
  // two stages before use; the third stage only delays stage two
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  // sda moving while scl stays high is framing, never data
  assign scl_rise   = scl_s2 & ~scl_d;
  assign scl_fall   = ~scl_s2 & scl_d;
  assign start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_seen  = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ***************************************************************
  // framing state machine
  // ***************************************************************
  // full buffer or running write both refuse the word by no ack
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      state        <= ST_IDLE;
      bit_cnt      <= 3'h0;
      shift        <= 8'h00;
      first_word   <= 1'b0;
      is_read      <= 1'b0;
      wrote        <= 1'b0;
      push         <= 1'b0;
      push_data    <= 8'h00;
      sda_out      <= 1'b0;
      sda_oe_out   <= 1'b0;
      tx_ready_out <= 1'b0;
      standby_out  <= 1'b0;
    end else begin
      push         <= 1'b0;
      tx_ready_out <= 1'b0;
      if (start_seen) begin
        state       <= ST_RX;
        bit_cnt     <= 3'h0;
        first_word  <= 1'b1;
        is_read     <= 1'b0;
        wrote       <= 1'b0;
        sda_oe_out  <= 1'b0;
        standby_out <= 1'b0;
      end else if (stop_seen) begin
        state      <= ST_IDLE;
        wrote      <= 1'b0;
        sda_oe_out <= 1'b0;
        if (is_read)
          standby_out <= 1'b1;
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s2};
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == `TWB_LAST_BIT)
                state <= ST_RX_ACK;
            end
          end
          ST_RX_ACK: begin
            if (scl_fall) begin
              if (fifo_in_ready && !write_busy_out) begin
                sda_oe_out <= 1'b1;
                push       <= 1'b1;
                push_data  <= shift;
                first_word <= 1'b0;
                state      <= ST_ACK;
                if (first_word && shift[`TWB_READ_FLAG_BIT])
                  is_read <= 1'b1;
                else if (!is_read)
                  wrote <= ~first_word;
              end else begin
                state <= ST_IDLE;                   // ignore until start
              end
            end
          end
          ST_ACK, ST_TX_LOAD: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (is_read) begin
                shift        <= tx_data_in;
                sda_oe_out   <= ~tx_data_in[7];
                tx_ready_out <= 1'b1;
                state        <= ST_TX;
              end else begin
                sda_oe_out <= 1'b0;
                state      <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == `TWB_LAST_BIT)
                state <= ST_TX_REL;
            end else if (scl_fall) begin
              shift      <= {shift[6:0], 1'b0};
              sda_oe_out <= ~shift[6];
            end
          end
          ST_TX_REL: begin
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              state      <= ST_TX_ACK;
            end
          end
          ST_TX_ACK: begin
            // host ack asks for more; no ack ends the read
            if (scl_rise)
              state <= sda_s2 ? ST_IDLE : ST_TX_LOAD;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ***************************************************************
  // internal write timer
  // ***************************************************************
  // a stop that closes a write with data starts the timed cycle
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      wr_cnt         <= {`TWB_WRITE_CNT_BITS{1'b0}};
      write_busy_out <= 1'b0;
      write_done_out <= 1'b0;
    end else begin
      write_done_out <= 1'b0;
      if (write_busy_out) begin
        wr_cnt <= wr_cnt + 1'b1;
        if (wr_cnt == WR_LAST) begin
          write_busy_out <= 1'b0;
          write_done_out <= 1'b1;
        end
      end else if (stop_seen && wrote && !is_read) begin
        write_busy_out <= 1'b1;
        wr_cnt         <= {`TWB_WRITE_CNT_BITS{1'b0}};
      end
    end
  end

  // ***************************************************************
  // receive buffer and registered output stage
  // ***************************************************************
  assign fifo_take = fifo_out_valid & (~rx_valid_out | rx_ready_in);

  byte_fifo #(
    .WIDTH (`TWB_FIFO_WIDTH),
    .DEPTH (`TWB_FIFO_DEPTH)
  ) rx_fifo (
    .clk_in        (sys_clk_in),
    .rst_in        (srst_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (push_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_take),
    .out_data_out  (fifo_out_data)
  );

  // output word held until the user takes it
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      rx_valid_out <= 1'b0;
      rx_data_out  <= 8'h00;
    end else if (fifo_take) begin
      rx_valid_out <= 1'b1;
      rx_data_out  <= fifo_out_data;
    end else if (rx_ready_in) begin
      rx_valid_out <= 1'b0;
    end
  end
endmodule
